// file: rtl/itiu_regs.vh
// Constants for the interval timer and interrupt unit.
`ifndef ITIU_REGS_VH
`define ITIU_REGS_VH
`define CLK_PERIOD_NS 100
`define UNIT_SLOW_US 64
`define UNIT_FAST_US 8
`define UNIT_SLOW_CYC ((`UNIT_SLOW_US * 1000) / `CLK_PERIOD_NS)
`define UNIT_FAST_CYC ((`UNIT_FAST_US * 1000) / `CLK_PERIOD_NS)
`define NUM_TIMERS 10
`define NUM_SRC 16
`define CNT_W 8
`define PRE_W 10
`define CODE_NONE 8'hff
`define CODE_BASE 8'hc7
`define MASK_RST 16'h0000
`endif

// file: rtl/interval_timer.v
// One 8-bit interval timer that fires a pulse when its count reaches zero.
`include "itiu_regs.vh"
module interval_timer (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    input wire i_ce,
    // Control
    input wire i_load,
    input wire [`CNT_W-1:0] i_count,
    input wire i_tick,
    // Event
    output reg o_fire
);
    reg [`CNT_W-1:0] cnt_ff;
    reg run_ff;
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            cnt_ff <= 8'h00;
            run_ff <= 1'b0;
            o_fire <= 1'b0;
        end else if (i_ce) begin
            o_fire <= 1'b0;
            if (i_load) begin
                // A zero load asks at once; others restart even mid-run.
                cnt_ff <= i_count; // [R11] [R12]
                run_ff <= (i_count != 8'h00);
                o_fire <= (i_count == 8'h00); // [R11]
            end else if (run_ff && i_tick) begin
                cnt_ff <= cnt_ff - 8'h01; // [R4]
                if (cnt_ff == 8'h01) begin
                    run_ff <= 1'b0;
                    o_fire <= 1'b1; // [R5]
                end
            end
        end
    end
endmodule

// file: rtl/interval_timer_interrupt_unit.v
// Ten interval timers, a line clock and a sixteen-source priority interrupt unit.
// What this block does
// [R1] Ten independent interval timers.
// [R2] Timers count once every 64 us by default.
// [R3] With high rate selected, timers count once every 8 us.
// [R4] Timer intervals run from 1 to 255 time units.
// [R5] A timer reaching zero requests its interrupt, gated by its enable.
// [R6] Each line-clock tick sets a poll flag or requests an interrupt.
// [R7] Sixteen sources arbitrated by fixed priority, timer six highest.
// [R8] A global mask blocks every maskable interrupt request at once.
// [R9] A per-source mask enables or inhibits each source.
// [R10] Two off-card requests accepted: one maskable, one not.
// [R11] Loading a count starts the timer; loading zero requests at once.
// [R12] A count may be rewritten at any time, even while running.
// [R13] Mask one enables, zero inhibits; requests stay latched while masked.
// [R14] Poll returns highest enabled pending code and clears it, else 0ffh.
// [R15] Request output asserts only for enabled pending requests when unblocked.
`include "itiu_regs.vh"
module interval_timer_interrupt_unit (
    // Clock, reset, enable
    input wire I_CLK,
    input wire I_RESET_N,
    input wire I_CE,
    // Timer loading
    input wire I_LOAD,
    input wire [3:0] I_LOAD_SEL,
    input wire [7:0] I_LOAD_COUNT,
    // Control
    input wire I_HIGH_RATE_SELECT,
    input wire I_GLOBAL_ENABLE,
    input wire [15:0] I_SRC_MASK,
    input wire I_RTC_INT_MODE,
    input wire I_RTC_FLAG_CLR,
    // Event sources
    input wire I_LINE_TICK,
    input wire [5:0] I_EXT_SRC,
    input wire I_OFFCARD_INT,
    input wire I_OFFCARD_NMI,
    // Service
    input wire I_POLL,
    input wire I_ACK,
    // Outputs
    output reg O_INT,
    output reg O_NMI,
    output reg O_RTC_FLAG,
    output reg O_CODE_VALID,
    output reg [7:0] O_CODE,
    output reg [15:0] O_PENDING
);
    // Source slots in priority order, slot 0 highest:
    // 0 t6, 1 t7, 2 port/offcard, 3 t8, 4 s2 rx, 5 s2 tx, 6 t9, 7 t10,
    // 8 t1, 9 t2, 10 rtc, 11 t3, 12 s1 rx, 13 s1 tx, 14 t4, 15 t5.
    reg [`PRE_W-1:0] pre_ff;
    reg tick_ff;
    reg [15:0] pend_ff;
    reg [15:0] nxt_pend;
    wire [`NUM_TIMERS-1:0] fire;
    wire [15:0] evt;
    wire [15:0] live;
    reg [3:0] win;
    reg found;
    integer k;

    // One shared prescaler; a rate change applies at once to the unit already in progress.
    localparam [`PRE_W-1:0] SLOW_END = `UNIT_SLOW_CYC - 1;
    localparam [`PRE_W-1:0] FAST_END = `UNIT_FAST_CYC - 1;
    wire [`PRE_W-1:0] unit_end = I_HIGH_RATE_SELECT ? FAST_END : SLOW_END; // [R2] [R3]
    always @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            pre_ff <= 10'h000;
            tick_ff <= 1'b0;
        end else if (I_CE) begin
            tick_ff <= (pre_ff >= unit_end);
            pre_ff <= (pre_ff >= unit_end) ? 10'h000 : pre_ff + 10'h001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_TIMERS; g = g + 1) begin : tmr
            interval_timer u_tmr (
                .i_clk(I_CLK),
                .i_reset_n(I_RESET_N),
                .i_ce(I_CE),
                .i_load(I_LOAD && (I_LOAD_SEL == g)), // [R1]
                .i_count(I_LOAD_COUNT),
                .i_tick(tick_ff),
                .o_fire(fire[g])
            );
        end
    endgenerate

    // Timer index g is timer g+1.
    assign evt = {fire[4], fire[3], I_EXT_SRC[5], I_EXT_SRC[4], fire[2],
                  I_LINE_TICK && I_RTC_INT_MODE, fire[1], fire[0],
                  fire[9], fire[8], I_EXT_SRC[3], I_EXT_SRC[2], fire[7],
                  I_EXT_SRC[0] | I_OFFCARD_INT, fire[6], fire[5]}; // [R7] [R10] [R6]

    // Requests latch regardless of mask so unmasking later still serves them.
    assign live = pend_ff & I_SRC_MASK; // [R9] [R13]

    always @* begin
        win = 4'h0;
        found = 1'b0;
        for (k = 15; k >= 0; k = k - 1) begin
            if (live[k]) begin
                win = k[3:0]; // [R7]
                found = 1'b1;
            end
        end
    end

    always @* begin
        nxt_pend = pend_ff;
        if ((I_POLL || I_ACK) && found) begin
            nxt_pend[win] = 1'b0; // [R14]
        end
        // Set wins over a same-cycle clear.
        nxt_pend = nxt_pend | evt; // [R5] [R13]
    end

    always @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            pend_ff <= `MASK_RST;
            O_INT <= 1'b0;
            O_NMI <= 1'b0;
            O_RTC_FLAG <= 1'b0;
            O_CODE_VALID <= 1'b0;
            O_CODE <= `CODE_NONE;
            O_PENDING <= 16'h0000;
        end else if (I_CE) begin
            pend_ff <= nxt_pend;
            O_PENDING <= nxt_pend;
            O_INT <= I_GLOBAL_ENABLE && ((nxt_pend & I_SRC_MASK) != 16'h0000); // [R8] [R15]
            O_NMI <= I_OFFCARD_NMI; // [R10]
            if (I_LINE_TICK && !I_RTC_INT_MODE) begin
                O_RTC_FLAG <= 1'b1; // [R6]
            end else if (I_RTC_FLAG_CLR) begin
                O_RTC_FLAG <= 1'b0;
            end
            O_CODE_VALID <= I_POLL || I_ACK;
            if (I_POLL || I_ACK) begin
                // Codes step by 8 per slot like restart opcodes.
                O_CODE <= found ? (`CODE_BASE + {2'b00, win[2:0], 3'b000} +
                    (win[3] ? 8'h40 : 8'h00)) : `CODE_NONE; // [R14]
            end
        end
    end
endmodule

// file: dv/itiu_chk.sv
// Port checker for the interval timer interrupt unit.
module itiu_chk(
    input wire I_CLK, input wire I_RESET_N, input wire I_CE, input wire I_POLL,
    input wire I_ACK, input wire I_GLOBAL_ENABLE, input wire [15:0] I_SRC_MASK,
    input wire I_LINE_TICK, input wire I_RTC_INT_MODE, input wire I_OFFCARD_NMI,
    input wire O_INT, input wire O_NMI, input wire O_RTC_FLAG, input wire O_CODE_VALID,
    input wire [7:0] O_CODE, input wire [15:0] O_PENDING);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    wire pl = I_POLL | I_ACK;
    wire en0 = (O_PENDING & I_SRC_MASK) == 16'h0000;
    AST_NMI: assert property (I_CE |=> O_NMI == $past(I_OFFCARD_NMI)) else $error("nmi");
    AST_GMASK: assert property (I_CE && !I_GLOBAL_ENABLE |=> !O_INT) else $error("gmask");
    AST_NOPEND: assert property (I_CE |=> O_INT == ($past(I_GLOBAL_ENABLE) &&
        ((O_PENDING & $past(I_SRC_MASK)) != 16'h0000))) else $error("int");
    AST_ANS: assert property (I_CE && pl |=> O_CODE_VALID) else $error("ans");
    AST_VALID: assert property (O_CODE_VALID && $past(I_CE) |-> $past(pl))
        else $error("valid");
    AST_EMPTY: assert property (I_CE && pl && en0 |=> O_CODE == 8'hff) else $error("ff");
    AST_TOP: assert property (I_CE && pl && O_PENDING[0] && I_SRC_MASK[0]
        |=> O_CODE == 8'hc7 && !O_PENDING[0]) else $error("top");
    AST_LATCH: assert property (O_PENDING[3] && !pl |=> O_PENDING[3]) else $error("latch");
    AST_RTC: assert property (I_CE && I_LINE_TICK && !I_RTC_INT_MODE |=> O_RTC_FLAG)
        else $error("rtc");
    cover property (O_CODE_VALID && O_CODE == 8'hc7);
    cover property ($rose(O_INT));
    cover property ($rose(O_RTC_FLAG));
endmodule
bind interval_timer_interrupt_unit itiu_chk i_chk(.*);

// file: dv/itiu_host.sv
// Host model that acknowledges raised interrupt requests while enabled.
module itiu_host(input wire i_clk, input wire i_en, input wire i_int, output reg o_ack);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_ack = 1'b0;
    // Acks every other cycle while enabled and the request is high; the request output drops on the same edge as the clear.
    always @(negedge i_clk) o_ack <= i_en && i_int && !o_ack;
endmodule

// file: dv/tb_interval_timer_interrupt_unit.sv
// Self-checking bench for the interval timer interrupt unit.
module tb_interval_timer_interrupt_unit;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk=0, rst_n=0, ce=1, ld=0, hr=0, ge=0, rm=0, fc=0, lt=0, nmi=0, poll=0, hen=0, oi=0;
    reg [3:0] sel=0;
    reg [5:0] ext=0;
    reg [7:0] cnt=0;
    reg [15:0] msk=0;
    wire ack, o_int, o_nmi, o_rf, cv;
    wire [7:0] code;
    wire [15:0] pend;
    integer err_count=0, checked=0;
    always #50 clk = ~clk;
    interval_timer_interrupt_unit i_dut(.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce),
        .I_LOAD(ld), .I_LOAD_SEL(sel), .I_LOAD_COUNT(cnt), .I_HIGH_RATE_SELECT(hr),
        .I_GLOBAL_ENABLE(ge), .I_SRC_MASK(msk), .I_RTC_INT_MODE(rm), .I_RTC_FLAG_CLR(fc),
        .I_LINE_TICK(lt), .I_EXT_SRC(ext), .I_OFFCARD_INT(oi), .I_OFFCARD_NMI(nmi),
        .I_POLL(poll), .I_ACK(ack), .O_INT(o_int), .O_NMI(o_nmi), .O_RTC_FLAG(o_rf),
        .O_CODE_VALID(cv), .O_CODE(code), .O_PENDING(pend));
    itiu_host i_host(.i_clk(clk), .i_en(hen), .i_int(o_int), .o_ack(ack));
    task chk(input string n, input logic [15:0] g, input logic [15:0] e); begin
        checked = checked + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    end endtask
    task cyc(input integer k); repeat (k) @(negedge clk); endtask
    task load(input [3:0] s, input [7:0] c); begin
        sel = s; cnt = c; ld = 1; cyc(1); ld = 0; cyc(1);
    end endtask
    task dopoll(input [7:0] e); begin
        poll = 1;
        cyc(1);
        poll = 0;
        chk("valid", cv, 1);
        chk("code", code, e);
        cyc(1);
        chk("valid", cv, 0);
    end endtask
    task t_zero; begin
        load(4'h5, 0);
        load(4'h6, 0);
        load(4'h7, 0);
        cyc(3);
        chk("pend", pend & 16'h000b, 16'h000b);
        chk("int", o_int, 0);
        msk = 16'hffff;
        ge = 1;
        cyc(2);
        chk("int", o_int, 1);
        ge = 0;
        cyc(2);
        chk("int", o_int, 0);
        dopoll(8'hc7);
        dopoll(8'hcf);
        dopoll(8'hdf);
        dopoll(8'hff);
    end endtask
    task t_rate; begin
        load(4'h0, 8'h05);
        load(4'h0, 8'h02);
        cyc(600);
        chk("slow", pend[8], 0);
        cyc(690);
        chk("slow", pend[8], 1);
        dopoll(8'h07);
        hr = 1;
        load(4'h9, 8'hff);
        load(4'h9, 8'h03);
        cyc(150);
        chk("fast", pend[7], 0);
        cyc(100);
        chk("fast", pend[7], 1);
        dopoll(8'hff);
        chk("clr", pend[7], 0);
        hr = 0;
    end endtask
    task t_rtc; begin
        lt = 1;
        cyc(1);
        lt = 0;
        cyc(1);
        chk("flag", o_rf, 1);
        fc = 1;
        cyc(1);
        fc = 0;
        cyc(1);
        chk("flag", o_rf, 0);
        rm = 1;
        nmi = 1;
        lt = 1;
        cyc(1);
        lt = 0;
        cyc(2);
        chk("rtc", pend[10], 1);
        chk("nmi", o_nmi, 1);
        ge = 1;
        hen = 1;
        cyc(8);
        chk("ack", pend[10], 0);
        hen = 0;
        oi = 1;
        cyc(1);
        oi = 0;
        cyc(2);
        chk("off", pend[2], 1);
        msk = 16'hfffb;
        dopoll(8'hff);
        chk("held", pend[2], 1);
        msk = 16'hffff;
        dopoll(8'hd7);
    end endtask
    task t_ext; begin
        ext = 6'h3c;
        cyc(1);
        ext = 6'h00;
        cyc(1);
        chk("ext", pend & 16'h3030, 16'h3030);
        dopoll(8'he7);
        dopoll(8'hef);
        dopoll(8'h27);
        dopoll(8'h2f);
    end endtask
    task t_ce; begin
        rm = 0;
        ce = 0;
        lt = 1;
        cyc(1);
        lt = 0;
        ce = 1;
        cyc(1);
        chk("freeze", o_rf, 0);
        nmi = 0;
        cyc(2);
        chk("nmi", o_nmi, 0);
    end endtask
    task end_sim; begin
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end endtask
    initial begin
        cyc(6);
        rst_n = 1;
        cyc(1);
        t_zero;
        t_rate;
        t_rtc;
        t_ext;
        t_ce;
        end_sim;
    end
    initial begin #400000; err_count = err_count + 1; end_sim; end
endmodule
